// ==== logic/pcfn_pin_drive.sv ====
// Registered pin driver: picks address or general data and the enable
`timescale 1ns/1ns

module pcfn_pin_drive #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] addr_sel,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] gpio_out,
  input  wire logic [W-1:0] ext_addr,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_n,
  output logic      [W-1:0] gpio_in
);

  // ==========================================================
  // Output value: address bit or port data bit per pin
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_o <= W'(pcfn_pkg::PIN_O_RESET);
    end else begin
      pin_o <= (addr_sel & ext_addr) | (~addr_sel & gpio_out);
    end
  end

  // ==========================================================
  // Enable low means driving; address pins always drive
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_oe_n <= W'(pcfn_pkg::PIN_OE_N_RESET);
    end else begin
      pin_oe_n <= ~(addr_sel | dir);
    end
  end

  // ==========================================================
  // Pin level seen by general use; address pins read as zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gpio_in <= W'(pcfn_pkg::READ_ZERO);
    end else begin
      gpio_in <= pin_i & ~addr_sel;
    end
  end

endmodule : pcfn_pin_drive

// ==== logic/pcfn_pkg.sv ====
// Constants, carriers and helpers shared by the port C pin function block
package pcfn_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 4;
  localparam int PIN_W  = 16;

  // ==========================================================
  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] DIR_OFS  = 4'h0;
  localparam logic [ADDR_W-1:0] FUNC_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] MODE_OFS = 4'h6;

  // ==========================================================
  // Values after reset, and the all-address selection mask
  localparam logic [PIN_W-1:0] DIR_RESET      = 16'h0000;
  localparam logic [PIN_W-1:0] FUNC_RESET     = 16'h0000;
  localparam logic [PIN_W-1:0] READ_ZERO      = 16'h0000;
  localparam logic [PIN_W-1:0] ALL_ADDR       = 16'hFFFF;
  localparam logic [PIN_W-1:0] PIN_OE_N_RESET = 16'hFFFF;
  localparam logic [PIN_W-1:0] PIN_O_RESET    = 16'h0000;

  // ==========================================================
  // Operating modes, one-hot
  typedef enum logic [2:0] {
    PCFN_MODE_NORMAL = 3'b001,
    PCFN_MODE_SINGLE = 3'b010,
    PCFN_MODE_ROMOFF = 3'b100
  } pcfn_mode_type;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [PIN_W-1:0]  wdata;
    logic              wr;
    logic              rd;
  } pcfn_bus_req_type;

  typedef struct packed {
    logic [PIN_W-1:0] o;
    logic [PIN_W-1:0] oe_n;
  } pcfn_pin_out_type;

  // ==========================================================
  // Helpers
  // Mode straps; ROM-off wins if both are raised
  function automatic pcfn_mode_type pcfn_decode_mode(logic single, logic romoff);
    if (romoff) begin
      return PCFN_MODE_ROMOFF;
    end
    if (single) begin
      return PCFN_MODE_SINGLE;
    end
    return PCFN_MODE_NORMAL;
  endfunction : pcfn_decode_mode

  // Effective per-pin address selection after the mode override
  function automatic logic [PIN_W-1:0] pcfn_addr_sel(pcfn_mode_type m,
                                                    logic [PIN_W-1:0] func);
    logic [PIN_W-1:0] sel;
    sel = func;
    if (m == PCFN_MODE_SINGLE) begin
      sel = READ_ZERO;
    end
    if (m == PCFN_MODE_ROMOFF) begin
      sel = ALL_ADDR;
    end
    return sel;
  endfunction : pcfn_addr_sel

endpackage : pcfn_pkg

// ==== logic/pcfn_port_c.sv ====
// Port C pin function and direction control with its register port
`timescale 1ns/1ns

module pcfn_port_c #(
  parameter int ADDR_W      = pcfn_pkg::ADDR_W,
  parameter int PIN_W       = pcfn_pkg::PIN_W,
  parameter bit HAS_PORT_C  = 1'b1
) (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       wdog_rst,
  input  wire logic                       mode_single_chip,
  input  wire logic                       mode_rom_off,
  input  wire pcfn_pkg::pcfn_bus_req_type bus_req,
  output logic [PIN_W-1:0]                bus_rdata,
  input  wire logic [PIN_W-1:0]           gpio_out_data,
  input  wire logic [PIN_W-1:0]           external_address_bit,
  input  wire logic [PIN_W-1:0]           pin_i,
  output pcfn_pkg::pcfn_pin_out_type      pin_out,
  output logic [PIN_W-1:0]                gpio_in_data,
  output logic [PIN_W-1:0]                pin_is_addr
);

  // ==========================================================
  // Storage and decode
  logic [PIN_W-1:0]        port_c_direction_reg;
  logic [PIN_W-1:0]        port_c_function_select_reg;
  pcfn_pkg::pcfn_mode_type mode_reg;
  logic [PIN_W-1:0]        rdata_reg;
  logic [PIN_W-1:0]        rdata_next;
  logic [PIN_W-1:0]        addr_sel;
  logic                    wr_dir;
  logic                    wr_func;
  logic [PIN_W-1:0]        drv_o;
  logic [PIN_W-1:0]        drv_oe_n;

  // Write decode; variants without the pins ignore writes
  assign wr_dir  = HAS_PORT_C && bus_req.wr
                   && (bus_req.addr == pcfn_pkg::DIR_OFS);
  assign wr_func = HAS_PORT_C && bus_req.wr
                   && (bus_req.addr == pcfn_pkg::FUNC_OFS);

  // ==========================================================
  // Direction register
  // Only the power-on reset clears it; the watchdog reset has no path
  // here so software settings survive it (standby and sleep likewise).
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_c_direction_reg <= pcfn_pkg::DIR_RESET;
    end else if (wr_dir) begin
      port_c_direction_reg <= bus_req.wdata;
    end
  end

  // ==========================================================
  // Function-select register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_c_function_select_reg <= pcfn_pkg::FUNC_RESET;
    end else if (wr_func) begin
      port_c_function_select_reg <= bus_req.wdata;
    end
  end

  // ==========================================================
  // Operating mode straps
  // Caught on a clocked edge while either reset is held, never by an
  // asynchronous load; a change on the straps later has no effect.
  always_ff @(posedge mclk) begin
    if (sys_rst || wdog_rst) begin
      mode_reg <= pcfn_pkg::pcfn_decode_mode(mode_single_chip, mode_rom_off);
    end
  end

  // ==========================================================
  // Effective pin function after the mode override
  always_comb begin
    unique case (mode_reg)
      pcfn_pkg::PCFN_MODE_NORMAL: begin
        addr_sel = port_c_function_select_reg;
      end
      pcfn_pkg::PCFN_MODE_SINGLE: begin
        addr_sel = pcfn_pkg::READ_ZERO;
      end
      pcfn_pkg::PCFN_MODE_ROMOFF: begin
        addr_sel = pcfn_pkg::ALL_ADDR;
      end
      default: begin
        // Only before the first reset has caught the straps
        addr_sel = pcfn_pkg::READ_ZERO;
      end
    endcase
  end

  // ==========================================================
  // Pin driver; direction only reaches pins in general use
  pcfn_pin_drive #(
    .W (PIN_W)
  ) u_pin_drive (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .addr_sel (addr_sel),
    .dir      (port_c_direction_reg & ~addr_sel),
    .gpio_out (gpio_out_data),
    .ext_addr (external_address_bit),
    .pin_i    (pin_i),
    .pin_o    (drv_o),
    .pin_oe_n (drv_oe_n),
    .gpio_in  (gpio_in_data)
  );

  assign pin_out.o    = drv_o;
  assign pin_out.oe_n = drv_oe_n;

  // ==========================================================
  // Status: which pins currently carry the address
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_is_addr <= pcfn_pkg::READ_ZERO;
    end else begin
      pin_is_addr <= addr_sel;
    end
  end

  // ==========================================================
  // Read data mux
  // Stored values come back unchanged even when the mode overrides them,
  // so software can restore settings after a mode change.
  always_comb begin
    rdata_next = pcfn_pkg::READ_ZERO;
    if (bus_req.rd && HAS_PORT_C) begin
      unique case (bus_req.addr)
        pcfn_pkg::DIR_OFS: begin
          rdata_next = port_c_direction_reg;
        end
        pcfn_pkg::FUNC_OFS: begin
          rdata_next = port_c_function_select_reg;
        end
        pcfn_pkg::STAT_OFS: begin
          rdata_next = addr_sel;
        end
        pcfn_pkg::MODE_OFS: begin
          rdata_next = PIN_W'(mode_reg);
        end
        default: begin
          rdata_next = pcfn_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_reg <= pcfn_pkg::READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  // ==========================================================
  // Checks on the register side
  a_dir_write_lands: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_req.wr && bus_req.addr == pcfn_pkg::DIR_OFS && HAS_PORT_C)
      |=> (port_c_direction_reg == $past(bus_req.wdata)))
    else $error("direction write not stored");

  a_func_write_lands: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_req.wr && bus_req.addr == pcfn_pkg::FUNC_OFS && HAS_PORT_C)
      |=> (port_c_function_select_reg == $past(bus_req.wdata)))
    else $error("function write not stored");

  a_dir_por_clear: assert property (
    @(posedge mclk)
    sys_rst |=> (port_c_direction_reg == pcfn_pkg::DIR_RESET))
    else $error("direction not cleared by power-on reset");

  a_func_por_clear: assert property (
    @(posedge mclk)
    sys_rst |=> (port_c_function_select_reg == pcfn_pkg::FUNC_RESET
                 && pin_is_addr == pcfn_pkg::READ_ZERO))
    else $error("function not cleared by power-on reset");

  a_wdog_keeps_dir: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (wdog_rst && !bus_req.wr) |=> $stable(port_c_direction_reg))
    else $error("direction changed by watchdog reset");

  a_wdog_keeps_func: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (wdog_rst && !bus_req.wr)[*2] |-> $stable(port_c_function_select_reg))
    else $error("function changed by watchdog reset");

  a_read_returns_store: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_req.rd && bus_req.addr == pcfn_pkg::FUNC_OFS && HAS_PORT_C)
      |=> (bus_rdata == $past(port_c_function_select_reg)))
    else $error("read does not return stored function bits");

  a_read_dir_store: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_req.rd && bus_req.addr == pcfn_pkg::DIR_OFS && HAS_PORT_C)
      |=> (bus_rdata == $past(port_c_direction_reg)))
    else $error("read does not return stored direction bits");

  a_rdata_idle_zero: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !bus_req.rd |=> (bus_rdata == pcfn_pkg::READ_ZERO))
    else $error("read data present without a read");

  // ==========================================================
  // Checks on the pin side
  // The release edge still launches reset values, so it starts no attempt
  a_gpio_dir_drive: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> ((~pin_out.oe_n & ~$past(addr_sel))
              == ($past(port_c_direction_reg) & ~$past(addr_sel))))
    else $error("general pin enable does not follow direction bit");

  a_addr_ignores_dir: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> ((pin_out.oe_n & $past(addr_sel)) == pcfn_pkg::READ_ZERO))
    else $error("address pin not driven");

  a_addr_value_out: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> ((pin_out.o & $past(addr_sel))
              == ($past(external_address_bit) & $past(addr_sel))))
    else $error("address bit not on its pin");

  a_normal_uses_func: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (mode_reg == pcfn_pkg::PCFN_MODE_NORMAL)
      |-> (addr_sel == port_c_function_select_reg))
    else $error("normal mode ignores function bits");

  a_single_all_gpio: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (mode_reg == pcfn_pkg::PCFN_MODE_SINGLE)
      |=> (pin_is_addr == pcfn_pkg::READ_ZERO))
    else $error("single-chip mode left an address pin");

  a_romoff_all_addr: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!sys_rst && mode_reg == pcfn_pkg::PCFN_MODE_ROMOFF)
      |=> (pin_out.oe_n == pcfn_pkg::READ_ZERO))
    else $error("ROM-disabled mode left a pin undriven");

  a_absent_port_quiet: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!HAS_PORT_C) |-> (bus_rdata == pcfn_pkg::READ_ZERO))
    else $error("absent port returned data");

  // ==========================================================
  // Checks on register decode and storage
  // Nothing but a write of its own offset may move a register, so a
  // watchdog reset that cleared state by mistake shows up here.
  a_dir_only_by_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !(bus_req.wr && bus_req.addr == pcfn_pkg::DIR_OFS)
      |=> $stable(port_c_direction_reg))
    else $error("direction changed without a write");

  a_func_only_by_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !(bus_req.wr && bus_req.addr == pcfn_pkg::FUNC_OFS)
      |=> $stable(port_c_function_select_reg))
    else $error("function changed without a write");

  a_unmapped_read_zero: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_req.rd && bus_req.addr != pcfn_pkg::DIR_OFS
      && bus_req.addr != pcfn_pkg::FUNC_OFS
      && bus_req.addr != pcfn_pkg::STAT_OFS
      && bus_req.addr != pcfn_pkg::MODE_OFS)
      |=> (bus_rdata == pcfn_pkg::READ_ZERO))
    else $error("unmapped offset returned data");

  a_status_read: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_req.rd && bus_req.addr == pcfn_pkg::STAT_OFS && HAS_PORT_C)
      |=> (bus_rdata == $past(addr_sel)))
    else $error("status read does not show the address pins");

  a_mode_read: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_req.rd && bus_req.addr == pcfn_pkg::MODE_OFS && HAS_PORT_C)
      |=> (bus_rdata == PIN_W'($past(mode_reg))))
    else $error("mode read does not show the caught mode");

  // ==========================================================
  // Checks on the mode straps
  // Straps move the mode only while a reset is held; a strap that wobbles
  // in normal running must not swap the pins under running software.
  a_mode_held: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !(sys_rst || wdog_rst) |=> $stable(mode_reg))
    else $error("mode changed outside a reset");

  a_rom_strap_wins: assert property (
    @(posedge mclk)
    ((sys_rst || wdog_rst) && mode_rom_off)
      |=> (mode_reg == pcfn_pkg::PCFN_MODE_ROMOFF))
    else $error("ROM-disabled strap not caught");

  a_single_strap: assert property (
    @(posedge mclk)
    ((sys_rst || wdog_rst) && mode_single_chip && !mode_rom_off)
      |=> (mode_reg == pcfn_pkg::PCFN_MODE_SINGLE))
    else $error("single-chip strap not caught");

  a_sel_matches_mode: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (addr_sel == pcfn_pkg::pcfn_addr_sel(mode_reg, port_c_function_select_reg)))
    else $error("effective selection disagrees with the mode");

  // ==========================================================
  // Checks on the pin data paths
  a_gpio_value_out: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> ((pin_out.o & ~$past(addr_sel))
              == ($past(gpio_out_data) & ~$past(addr_sel))))
    else $error("port data not on general pin");

  a_gpio_in_level: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> ((gpio_in_data & ~$past(addr_sel))
              == ($past(pin_i) & ~$past(addr_sel))))
    else $error("general pin level not read back");

  // Address pins read as zero so software never mistakes the bus for data
  a_addr_reads_zero: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> ((gpio_in_data & $past(addr_sel)) == pcfn_pkg::READ_ZERO))
    else $error("address pin level leaked into port data");

  a_status_tracks_sel: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> (pin_is_addr == $past(addr_sel)))
    else $error("status does not follow the effective selection");

endmodule : pcfn_port_c

// ==== tb/pcfn_pin_partner.sv ====
// Far-side model of the port C pins and their external drivers
`timescale 1ns/1ns

module pcfn_pin_partner (
  input  wire pcfn_pkg::pcfn_pin_out_type pin_out,
  input  wire logic [15:0]                ext_level,
  output logic      [15:0]                pin_i
);
  // ==========================================================
  // Wire resolution
  // Undriven pins take the outside driver level, so a stale value never passes
  always_comb begin
    pin_i = (pin_out.o & ~pin_out.oe_n) | (ext_level & pin_out.oe_n);
  end
endmodule : pcfn_pin_partner

// ==== tb/pcfn_port_c_test.sv ====
// Self-checking bench for the port C pin function and direction block
`timescale 1ns/1ns

module pcfn_port_c_test;
  // ==========================================================
  // Signals and counters
  logic                       mclk;
  logic                       sys_rst;
  logic                       wdog_rst;
  logic                       mode_single_chip;
  logic                       mode_rom_off;
  pcfn_pkg::pcfn_bus_req_type bus_req;
  logic [15:0]                bus_rdata;
  logic [15:0]                gpio_out_data;
  logic [15:0]                external_address_bit;
  logic [15:0]                ext_level;
  logic [15:0]                pin_i;
  pcfn_pkg::pcfn_pin_out_type pin_out;
  logic [15:0]                gpio_in_data;
  logic [15:0]                pin_is_addr;
  int                         fail_count;
  int                         checks;
  localparam logic [15:0] DIR_VAL  = 16'hA5C3;
  localparam logic [15:0] FUNC_VAL = 16'h00F0;

  // ==========================================================
  // Design and pin model
  pcfn_port_c dut (
    .mclk                 (mclk),
    .sys_rst              (sys_rst),
    .wdog_rst             (wdog_rst),
    .mode_single_chip     (mode_single_chip),
    .mode_rom_off         (mode_rom_off),
    .bus_req              (bus_req),
    .bus_rdata            (bus_rdata),
    .gpio_out_data        (gpio_out_data),
    .external_address_bit (external_address_bit),
    .pin_i                (pin_i),
    .pin_out              (pin_out),
    .gpio_in_data         (gpio_in_data),
    .pin_is_addr          (pin_is_addr)
  );

  pcfn_pin_partner u_pins (
    .pin_out   (pin_out),
    .ext_level (ext_level),
    .pin_i     (pin_i)
  );

  // ==========================================================
  // Clock, 8 ns period
  initial begin
    mclk = 1'b0;
  end
  always #4 mclk = ~mclk;

  // ==========================================================
  // Shared tasks
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe
  task automatic reg_write(input logic [3:0] addr, input logic [15:0] data);
    @(posedge mclk);
    bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] addr, input logic [15:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    check(bus_rdata, exp);
  endtask : reg_read

  // Expected pin state from selection and direction; waits for both pipeline stages
  task automatic check_pins(input logic [15:0] sel, input logic [15:0] dir);
    logic [15:0] drv;
    logic [15:0] lvl;
    drv = sel | dir;
    lvl = (sel & external_address_bit) | (dir & ~sel & gpio_out_data) | (~drv & ext_level);
    repeat (3) @(posedge mclk);
    #1;
    check(pin_is_addr, sel);
    check(pin_out.oe_n, ~drv);
    check(pin_out.o & drv, lvl & drv);
    check(gpio_in_data, lvl & ~sel);
  endtask : check_pins

  // Power-on or watchdog reset for two cycles with new mode straps
  task automatic pulse_reset(input logic por, input logic single, input logic romoff);
    @(posedge mclk);
    mode_single_chip <= single;
    mode_rom_off     <= romoff;
    if (por) begin
      sys_rst <= 1'b1;
    end else begin
      wdog_rst <= 1'b1;
    end
    repeat (2) @(posedge mclk);
    sys_rst  <= 1'b0;
    wdog_rst <= 1'b0;
  endtask : pulse_reset

  // Verdict, reached from the main sequence or the hang guard
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Hang guard, far above the length of the sequence
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence; the bench models a build with the pins, so no access is illegal
  initial begin
    fail_count           = 0;
    checks               = 0;
    sys_rst              = 1'b1;
    wdog_rst             = 1'b0;
    mode_single_chip     = 1'b0;
    mode_rom_off         = 1'b0;
    bus_req              = '0;
    gpio_out_data        = 16'h3C5A;
    external_address_bit = 16'h9A6E;
    ext_level            = 16'h6B1D;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    reg_read(pcfn_pkg::DIR_OFS, 16'h0000);
    reg_read(pcfn_pkg::FUNC_OFS, 16'h0000);
    check_pins(16'h0000, 16'h0000);
    $display("test reset_values done");
    reg_write(pcfn_pkg::DIR_OFS, DIR_VAL);
    reg_read(pcfn_pkg::DIR_OFS, DIR_VAL);
    check_pins(16'h0000, DIR_VAL);
    $display("test direction done");
    reg_write(pcfn_pkg::FUNC_OFS, FUNC_VAL);
    reg_read(pcfn_pkg::FUNC_OFS, FUNC_VAL);
    check_pins(FUNC_VAL, DIR_VAL);
    $display("test normal_mode done");
    pulse_reset(1'b0, 1'b1, 1'b0);
    reg_read(pcfn_pkg::DIR_OFS, DIR_VAL);
    reg_read(pcfn_pkg::FUNC_OFS, FUNC_VAL);
    reg_read(pcfn_pkg::MODE_OFS, 16'h0002);
    check_pins(16'h0000, DIR_VAL);
    $display("test single_chip done");
    pulse_reset(1'b0, 1'b0, 1'b1);
    reg_read(pcfn_pkg::STAT_OFS, 16'hFFFF);
    reg_read(pcfn_pkg::MODE_OFS, 16'h0004);
    reg_read(pcfn_pkg::DIR_OFS, DIR_VAL);
    reg_read(pcfn_pkg::FUNC_OFS, FUNC_VAL);
    check_pins(16'hFFFF, DIR_VAL);
    $display("test rom_off done");
    pulse_reset(1'b0, 1'b1, 1'b1);
    reg_read(pcfn_pkg::MODE_OFS, 16'h0004);
    reg_write(4'h8, 16'hFFFF);
    reg_read(4'h8, 16'h0000);
    reg_write(pcfn_pkg::STAT_OFS, 16'h0000);
    reg_read(pcfn_pkg::STAT_OFS, 16'hFFFF);
    reg_read(pcfn_pkg::FUNC_OFS, FUNC_VAL);
    $display("test unmapped done");
    pulse_reset(1'b1, 1'b0, 1'b0);
    reg_read(pcfn_pkg::DIR_OFS, 16'h0000);
    reg_read(pcfn_pkg::FUNC_OFS, 16'h0000);
    check_pins(16'h0000, 16'h0000);
    $display("test power_on_again done");
    tally_and_finish();
  end
endmodule : pcfn_port_c_test
